//--- wwt_defs.svh
// constants of the watch timer and watchdog block
`ifndef WWT_DEFS_SVH
`define WWT_DEFS_SVH
// What this block does
// - mode bits 2..0 pick sub-clock, main/256, main/128, main/2 or main clock
// - watch counter is 21 bits wide, about a minute at sub-clock
// - in stop mode a main-clock tap halts, and the watch counter with it
// - with sub-clock selected the watch counter keeps counting through stop mode
// - mode bits 4..3 pick interval 2Hz, 4Hz, 16Hz or 1/64Hz
// - the selected watch clock also drives the display clock tick
// - after stop release, watch flag clear waits for the next sub-clock edge or 762 main-clock cycles, whichever comes first
// - an uncleared watch flag is set again by the next interval event
// - watchdog counter is 7 bits, advanced by each interval timer overflow
// - counter equal to compare field raises the watchdog request flag
// - reset-select bit turns a watchdog match into interrupt or CPU reset
// - counter-clear bit resets the watchdog counter, hardware drops it next cycle
// - shared offset 0xe8 writes the load register when load-target is 1
// - watchdog priority 11, watch priority 12, both use vector 0xffe0

// register offsets (byte addresses)
`define WWT_OFS_SHARED     8'he8
`define WWT_OFS_MODE       8'hec
`define WWT_OFS_STATUS     8'hf0
`define WWT_OFS_CTRL       8'hf4
`define WWT_OFS_COUNT      8'hf8
// field positions and widths
`define WWT_MODE_W         6
`define WWT_MODE_LOADSEL   5
`define WWT_CMP_CLR_BIT    7
`define WWT_STS_WATCH_BIT  0
`define WWT_STS_WDOG_BIT   1
`define WWT_CTRL_RSTSEL    0
`define WWT_CNT_W          21
`define WWT_WDOG_W         7
`define WWT_LOAD_LSB       13
// reset values
`define WWT_MODE_RST       6'h00
`define WWT_CMP_RST        7'h7f
`define WWT_RSTSEL_RST     1'b0
// clock select codes and divider exponents
`define WWT_CLK_SUB        3'h0
`define WWT_CLK_DIV256     3'h1
`define WWT_CLK_DIV128     3'h2
`define WWT_CLK_DIV2       3'h3
`define WWT_DIV256_EXP     5'h08
`define WWT_DIV128_EXP     5'h07
`define WWT_DIV2_EXP       5'h01
// interval codes and counter tap exponents
`define WWT_IVL_2HZ        2'h0
`define WWT_IVL_4HZ        2'h1
`define WWT_IVL_16HZ       2'h2
`define WWT_IVL_2HZ_EXP    5'h0e
`define WWT_IVL_4HZ_EXP    5'h0d
`define WWT_IVL_16HZ_EXP   5'h0b
`define WWT_IVL_64S_EXP    5'h15
// interrupt identity
`define WWT_IRQ_VECTOR     16'hffe0
`define WWT_WDOG_PRIO      4'hb
`define WWT_WATCH_PRIO     4'hc
// timing
`define WWT_MCLK_PERIOD_NS 40
`define WWT_STOP_CLR_HOLD_NS 30500
`define WWT_STOP_CLR_HOLD_CYC (`WWT_STOP_CLR_HOLD_NS / `WWT_MCLK_PERIOD_NS)
`endif

//--- wwt_pkg.sv
// types and shared function of the watch timer and watchdog block
`include "wwt_defs.svh"
package wwt_pkg;
  // state of the pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } wwt_sync_s;
  // state of the watchdog counter
  typedef struct packed {
    logic [`WWT_WDOG_W-1:0] cnt;
    logic                   match;
  } wwt_wdog_s;
  // state of the top block
  typedef struct packed {
    logic [7:0]             pre;
    logic [`WWT_CNT_W-1:0]  cnt;
    logic [`WWT_MODE_W-1:0] mode;
    logic [`WWT_WDOG_W-1:0] cmp;
    logic                   clrReq;
    logic                   rstSel;
    logic                   wFlag;
    logic                   dFlag;
    logic                   holdClr;
    logic [9:0]             holdCnt;
    logic                   stopPrev;
    logic [31:0]            rdata;
    logic                   dRst;
    logic                   lcdTick;
  } wwt_top_s;
  // true when the low k bits of v are all ones
  function automatic logic tap_hit(input logic [`WWT_CNT_W-1:0] v, input logic [4:0] k);
    logic [`WWT_CNT_W-1:0] mask;
    mask = (k >= 5'(`WWT_CNT_W)) ? '1 : ((`WWT_CNT_W'(1) << k) - `WWT_CNT_W'(1));
    return &(v | ~mask);
  endfunction
endpackage

//--- wwt_sync.sv
// three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/10ps
module wwt_sync import wwt_pkg::*; (
  input  logic mclk,      // system clock
  input  logic rstSyncN,  // synchronised reset, active low
  input  logic asyncIn,   // pin from outside the clock domain
  output logic levelOut,  // filtered level
  output logic riseOut    // one-cycle pulse on filtered rise
);
  wwt_sync_s state_q;
  wwt_sync_s state_d;

  // =====================================================
  // filter: change counts once stages two and three agree
  always_comb begin
    state_d       = state_q;
    state_d.s1    = asyncIn;
    state_d.s2    = state_q.s1;
    state_d.s3    = state_q.s2;
    state_d.level = (state_q.s2 == state_q.s3) ? state_q.s3 : state_q.level;
    state_d.rise  = state_d.level & ~state_q.level;
  end

  // state register
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign levelOut = state_q.level;
  assign riseOut  = state_q.rise;
endmodule

//--- wwt_wdog.sv
// seven-bit watchdog counter with compare match
`timescale 1ns/10ps
`include "wwt_defs.svh"
module wwt_wdog import wwt_pkg::*; (
  input  logic                   mclk,      // system clock
  input  logic                   rstSyncN,  // synchronised reset, active low
  input  logic                   tickIn,    // interval timer overflow pulse
  input  logic                   clrIn,     // counter clear pulse
  input  logic [`WWT_WDOG_W-1:0] cmpIn,     // compare value
  output logic [`WWT_WDOG_W-1:0] cntOut,    // counter value
  output logic                   matchOut   // one-cycle match pulse
);
  wwt_wdog_s              state_q;
  wwt_wdog_s              state_d;
  logic [`WWT_WDOG_W-1:0] nxt;

  // =====================================================
  // count, clear and compare
  always_comb begin
    state_d       = state_q;
    state_d.match = 1'b0;
    nxt           = state_q.cnt + `WWT_WDOG_W'(1);
    if (clrIn) begin
      state_d.cnt = '0;
    end else if (tickIn) begin
      if (nxt == cmpIn) begin
        state_d.cnt   = '0;
        state_d.match = 1'b1;
      end else begin
        state_d.cnt = nxt;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign cntOut   = state_q.cnt;
  assign matchOut = state_q.match;

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSyncN);

  property p_wdAdvance;
    (tickIn && !clrIn && (state_q.cnt + `WWT_WDOG_W'(1)) != cmpIn)
      |=> state_q.cnt == $past(state_q.cnt) + `WWT_WDOG_W'(1);
  endproperty
  a_wdAdvance: assert property (p_wdAdvance) else $error("watchdog did not advance");

  property p_wdMatch;
    matchOut |-> ($past(state_q.cnt) + `WWT_WDOG_W'(1)) == $past(cmpIn) && state_q.cnt == '0;
  endproperty
  a_wdMatch: assert property (p_wdMatch) else $error("watchdog match without equality");

  property p_wdClear;
    clrIn |=> state_q.cnt == '0 && !matchOut;
  endproperty
  a_wdClear: assert property (p_wdClear) else $error("watchdog clear did not zero count");

  c_wdMatch: cover property (matchOut);
endmodule

//--- wwt_top.sv
// watch timer and watchdog timer with APB register slave
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "wwt_defs.svh"
module wwt_top import wwt_pkg::*; (
  input  logic        mclk,              // system clock, 25 MHz
  input  logic        rstn,              // asynchronous reset, active low
  input  logic        psel,              // APB select
  input  logic        penable,           // APB enable
  input  logic        pwrite,            // APB direction, high for write
  input  logic [7:0]  paddr,             // APB byte address
  input  logic [31:0] pwdata,            // APB write data
  output logic [31:0] prdata,            // APB read data
  output logic        pready,            // APB ready
  output logic        pslverr,           // APB error on unmapped address
  input  logic        subClkPin,         // sub-clock oscillator pin
  input  logic        stopMode,          // CPU in stop mode, main taps halt
  input  logic        bitOverflow,       // interval timer overflow pulse
  output logic        watchIrq,          // watch interrupt request flag
  output logic        wdogIrq,           // watchdog interrupt request flag
  output logic        wdogCpuReset,      // watchdog CPU reset pulse
  output logic        lcdClkTick,        // display clock tick
  output logic [15:0] irqVector,         // shared interrupt vector
  output logic [3:0]  wdogIrqPriority,   // watchdog interrupt priority
  output logic [3:0]  watchIrqPriority   // watch interrupt priority
);
  localparam logic [9:0] HoldLast = 10'(`WWT_STOP_CLR_HOLD_CYC - 1);

  logic [1:0]             rstPipe_q;
  logic                   rstSyncN;
  wwt_top_s               state_q;
  wwt_top_s               state_d;
  logic                   subRise;
  logic                   srcTick;
  logic                   mainOn;
  logic [4:0]             ivlExp;
  logic                   wEvent;
  logic                   wrEn;
  logic                   rdSetup;
  logic                   hit;
  logic                   sharedWr;
  logic                   loadWr;
  logic                   cmpWr;
  logic                   wClr;
  logic                   dClr;
  logic                   stopRelease;
  logic [`WWT_WDOG_W-1:0] wdCnt;
  logic                   wdMatch;

  // =====================================================
  // reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_q[1];

  // =====================================================
  // sub-clock pin synchroniser
  wwt_sync u_subSync (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .asyncIn  (subClkPin),
    .levelOut (),
    .riseOut  (subRise)
  );

  // watchdog counter
  wwt_wdog u_wdog (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .tickIn   (bitOverflow),
    .clrIn    (state_q.clrReq),
    .cmpIn    (state_q.cmp),
    .cntOut   (wdCnt),
    .matchOut (wdMatch)
  );

  // =====================================================
  // watch clock selection
  always_comb begin
    mainOn = ~stopMode;
    unique case (state_q.mode[2:0])
      `WWT_CLK_SUB: begin
        srcTick = subRise;
      end
      `WWT_CLK_DIV256: begin
        srcTick = mainOn & tap_hit({13'h0, state_q.pre}, `WWT_DIV256_EXP);
      end
      `WWT_CLK_DIV128: begin
        srcTick = mainOn & tap_hit({13'h0, state_q.pre}, `WWT_DIV128_EXP);
      end
      `WWT_CLK_DIV2: begin
        srcTick = mainOn & tap_hit({13'h0, state_q.pre}, `WWT_DIV2_EXP);
      end
      default: begin
        srcTick = mainOn;
      end
    endcase
  end

  // interval tap of the watch counter
  always_comb begin
    unique case (state_q.mode[4:3])
      `WWT_IVL_2HZ:  ivlExp = `WWT_IVL_2HZ_EXP;
      `WWT_IVL_4HZ:  ivlExp = `WWT_IVL_4HZ_EXP;
      `WWT_IVL_16HZ: ivlExp = `WWT_IVL_16HZ_EXP;
      default:       ivlExp = `WWT_IVL_64S_EXP;
    endcase
  end
  assign wEvent = srcTick & tap_hit(state_q.cnt, ivlExp);

  // =====================================================
  // bus decode
  assign wrEn     = psel & penable & pwrite;
  assign rdSetup  = psel & ~penable;
  assign hit      = (paddr == `WWT_OFS_SHARED) | (paddr == `WWT_OFS_MODE) |
                    (paddr == `WWT_OFS_STATUS) | (paddr == `WWT_OFS_CTRL) |
                    (paddr == `WWT_OFS_COUNT);
  assign sharedWr = wrEn & (paddr == `WWT_OFS_SHARED);
  assign loadWr   = sharedWr & state_q.mode[`WWT_MODE_LOADSEL];
  assign cmpWr    = sharedWr & ~state_q.mode[`WWT_MODE_LOADSEL];
  assign stopRelease = state_q.stopPrev & ~stopMode;
  // watch clear is ignored while the post-stop hold is active
  assign wClr = wrEn & (paddr == `WWT_OFS_STATUS) & pwdata[`WWT_STS_WATCH_BIT] &
                ~state_q.holdClr;
  assign dClr = wrEn & (paddr == `WWT_OFS_STATUS) & pwdata[`WWT_STS_WDOG_BIT];

  // =====================================================
  // next state
  always_comb begin
    state_d          = state_q;
    state_d.stopPrev = stopMode;
    state_d.lcdTick  = srcTick;
    state_d.clrReq   = 1'b0;
    state_d.dRst     = wdMatch & state_q.rstSel;
    // prescaler only runs while the main clock runs
    if (mainOn) begin
      state_d.pre = state_q.pre + 8'h01;
    end
    // watch counter: load wins over a tick
    if (loadWr) begin
      state_d.cnt = {pwdata[7:0], `WWT_LOAD_LSB'(0)};
    end else if (srcTick) begin
      state_d.cnt = state_q.cnt + `WWT_CNT_W'(1);
    end
    // flags: a set in the clearing cycle wins
    state_d.wFlag = wEvent | (state_q.wFlag & ~wClr);
    state_d.dFlag = (wdMatch & ~state_q.rstSel) | (state_q.dFlag & ~dClr);
    // post-stop hold of the watch clear
    if (stopRelease) begin
      state_d.holdClr = 1'b1;
      state_d.holdCnt = 10'h000;
    end else if (state_q.holdClr) begin
      if (subRise || state_q.holdCnt == HoldLast) begin
        state_d.holdClr = 1'b0;
      end
      state_d.holdCnt = state_q.holdCnt + 10'h001;
    end
    // register writes
    if (cmpWr) begin
      state_d.cmp    = pwdata[`WWT_WDOG_W-1:0];
      state_d.clrReq = pwdata[`WWT_CMP_CLR_BIT];
    end
    if (wrEn && paddr == `WWT_OFS_MODE) begin
      state_d.mode = pwdata[`WWT_MODE_W-1:0];
    end
    if (wrEn && paddr == `WWT_OFS_CTRL) begin
      state_d.rstSel = pwdata[`WWT_CTRL_RSTSEL];
    end
    // read data captured in the setup cycle
    if (rdSetup) begin
      unique case (paddr)
        `WWT_OFS_SHARED: state_d.rdata = {25'h0, state_q.cmp};
        `WWT_OFS_MODE:   state_d.rdata = {26'h0, state_q.mode};
        `WWT_OFS_STATUS: state_d.rdata = {30'h0, state_q.dFlag, state_q.wFlag};
        `WWT_OFS_CTRL:   state_d.rdata = {24'h0, wdCnt, state_q.rstSel};
        `WWT_OFS_COUNT:  state_d.rdata = {11'h0, state_q.cnt};
        default:         state_d.rdata = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q        <= '0;
      state_q.mode   <= `WWT_MODE_RST;
      state_q.cmp    <= `WWT_CMP_RST;
      state_q.rstSel <= `WWT_RSTSEL_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================
  // outputs
  assign prdata           = state_q.rdata;
  assign pready           = 1'b1;
  assign pslverr          = psel & penable & ~hit;
  assign watchIrq         = state_q.wFlag;
  assign wdogIrq          = state_q.dFlag;
  assign wdogCpuReset     = state_q.dRst;
  assign lcdClkTick       = state_q.lcdTick;
  assign irqVector        = `WWT_IRQ_VECTOR;
  assign wdogIrqPriority  = `WWT_WDOG_PRIO;
  assign watchIrqPriority = `WWT_WATCH_PRIO;

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSyncN);

  property p_fastTap;
    (state_q.mode[2:0] == `WWT_CLK_DIV2 && !stopMode && !loadWr && state_q.pre[0])
      |=> state_q.cnt == $past(state_q.cnt) + `WWT_CNT_W'(1);
  endproperty
  a_fastTap: assert property (p_fastTap) else $error("main/2 tap missed a count");

  property p_wrap;
    (srcTick && &state_q.cnt && !loadWr) |=> state_q.cnt == '0 && state_q.wFlag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("watch counter did not wrap at 21 bits");

  property p_mainHalt;
    (stopMode && state_q.mode[2:0] != `WWT_CLK_SUB && !loadWr) |=> $stable(state_q.cnt);
  endproperty
  a_mainHalt: assert property (p_mainHalt) else $error("watch count moved in stop mode");

  property p_subRuns;
    (state_q.mode[2:0] == `WWT_CLK_SUB && subRise && !loadWr)
      |=> state_q.cnt == $past(state_q.cnt) + `WWT_CNT_W'(1);
  endproperty
  a_subRuns: assert property (p_subRuns) else $error("sub-clock count lost");

  property p_twoHz;
    (srcTick && !loadWr && state_q.mode[4:3] == `WWT_IVL_2HZ && &state_q.cnt[13:0])
      |=> state_q.wFlag;
  endproperty
  a_twoHz: assert property (p_twoHz) else $error("2Hz interval did not raise flag");

  property p_lcdTick;
    srcTick |=> lcdClkTick;
  endproperty
  a_lcdTick: assert property (p_lcdTick) else $error("display tick missing");

  property p_holdClr;
    (state_q.wFlag && state_q.holdClr) |=> state_q.wFlag;
  endproperty
  a_holdClr: assert property (p_holdClr) else $error("watch flag cleared during hold");

  property p_reset;
    (wdMatch && state_q.rstSel) |=> wdogCpuReset && !$rose(state_q.dFlag);
  endproperty
  a_reset: assert property (p_reset) else $error("watchdog reset select ignored");

  property p_shared;
    loadWr |=> $stable(state_q.cmp) && state_q.cnt[20:13] == $past(pwdata[7:0]);
  endproperty
  a_shared: assert property (p_shared) else $error("shared offset wrote wrong target");

  property p_flagCause;
    $rose(state_q.wFlag) |-> $past(srcTick);
  endproperty
  a_flagCause: assert property (p_flagCause) else $error("watch flag set without a tick");

  property p_irqFlag;
    (wdMatch && !state_q.rstSel) |=> wdogIrq && !wdogCpuReset;
  endproperty
  a_irqFlag: assert property (p_irqFlag) else $error("watchdog match raised no flag");

  property p_clrOnce;
    state_q.clrReq |=> !state_q.clrReq;
  endproperty
  a_clrOnce: assert property (p_clrOnce) else $error("counter clear bit stuck");

  property p_cmpWrite;
    cmpWr |=> state_q.cmp == $past(pwdata[`WWT_WDOG_W-1:0]);
  endproperty
  a_cmpWrite: assert property (p_cmpWrite) else $error("compare write lost");

  property p_holdEnd;
    (state_q.holdClr && subRise && !stopRelease) |=> !state_q.holdClr;
  endproperty
  a_holdEnd: assert property (p_holdEnd) else $error("hold outlived sub-clock edge");

  property p_lcdCause;
    lcdClkTick |-> $past(srcTick);
  endproperty
  a_lcdCause: assert property (p_lcdCause) else $error("display tick without source");

  property p_divHold;
    (state_q.mode[2:0] == `WWT_CLK_DIV256 && state_q.pre != 8'hff && !loadWr)
      |=> $stable(state_q.cnt);
  endproperty
  a_divHold: assert property (p_divHold) else $error("main/256 tap counted early");

  c_subInStop: cover property (stopMode && subRise && state_q.mode[2:0] == `WWT_CLK_SUB);
  c_watchFlag: cover property ($rose(state_q.wFlag));
  c_wdogReset: cover property (wdogCpuReset);
  c_holdEnd: cover property (state_q.holdClr && subRise);
endmodule

//--- wwt_tb.sv
// self-checking testbench of the watch timer and watchdog block
`timescale 1ns/10ps
`include "wwt_defs.svh"
module testbench import wwt_pkg::*;;
  localparam int TIMEOUT = 80000;  // ceiling in clock cycles
  logic        mclk, rstn, psel, penable, pwrite, subClkPin, stopMode, bitOverflow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, dlt;
  logic        pready, pslverr, err, watchIrq, wdogIrq, wdogCpuReset, lcdClkTick;
  logic [15:0] irqVector;
  logic [3:0]  wdogIrqPriority, watchIrqPriority;
  int          fails, compares, cycles, lcdCount, rstCount, n, l0;
  logic [31:0] tMode [5] = '{32'h04, 32'h0c, 32'h14, 32'h1c, 32'h13};
  logic [31:0] tLoad [5] = '{32'h00, 32'h00, 32'h00, 32'hfe, 32'h00};
  int          tTicks [5] = '{16383, 8191, 2047, 16383, 4094};

  wwt_top u_wwt_top (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subClkPin(subClkPin), .stopMode(stopMode),
    .bitOverflow(bitOverflow), .watchIrq(watchIrq), .wdogIrq(wdogIrq),
    .wdogCpuReset(wdogCpuReset), .lcdClkTick(lcdClkTick), .irqVector(irqVector),
    .wdogIrqPriority(wdogIrqPriority), .watchIrqPriority(watchIrqPriority));

  // ==========================================================
  // clock, event counters and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (lcdClkTick === 1'b1) lcdCount++;
    if (wdogCpuReset === 1'b1) rstCount++;
    if (cycles == TIMEOUT) begin
      fails++;
      stop_test();
    end
  end

  // ==========================================================
  // comparison and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // apb transfer: setup, access until pready, one idle edge after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // ==========================================================
  // stimulus helpers for overflow pulses, sub-clock and counting
  task automatic ovf(input int k);
    repeat (k) begin
      bitOverflow <= 1'b1;
      @(posedge mclk);
      bitOverflow <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task automatic sub_rise(input int k);
    repeat (k) begin
      subClkPin <= 1'b1;
      repeat (6) @(posedge mclk);
      subClkPin <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    while (watchIrq !== 1'b1 && c < 20000) begin
      @(posedge mclk);
      c++;
    end
  endtask
  // counter advance over a wait, or over sub-clock rises when rises > 0
  task automatic advance(input logic [31:0] mode, input int cyc, input int rises);
    logic [31:0] c0;
    wr(`WWT_OFS_MODE, mode);
    apb(1'b0, `WWT_OFS_COUNT, 32'h0);
    c0 = rd;
    if (rises > 0) sub_rise(rises);
    else repeat (cyc) @(posedge mclk);
    apb(1'b0, `WWT_OFS_COUNT, 32'h0);
    dlt = rd - c0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, subClkPin, stopMode, bitOverflow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    // constants and reset values
    chk(32'(irqVector), 32'hffe0);
    chk({24'h0, wdogIrqPriority, watchIrqPriority}, 32'hbc);
    rdchk(`WWT_OFS_MODE, 32'h0);
    rdchk(`WWT_OFS_SHARED, 32'h7f);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'(err), 32'h1);
    // watchdog count, match and flag
    wr(`WWT_OFS_SHARED, 32'h03);
    ovf(2);
    rdchk(`WWT_OFS_CTRL, 32'h04);
    chk(32'(wdogIrq), 32'h0);
    ovf(1);
    chk(32'(wdogIrq), 32'h1);
    rdchk(`WWT_OFS_STATUS, 32'h2);
    rdchk(`WWT_OFS_CTRL, 32'h00);
    wr(`WWT_OFS_STATUS, 32'h2);
    rdchk(`WWT_OFS_STATUS, 32'h0);
    // reset select turns the match into a cpu reset pulse
    wr(`WWT_OFS_CTRL, 32'h1);
    ovf(3);
    repeat (3) @(posedge mclk);
    chk(32'(rstCount), 32'h1);
    chk(32'(wdogIrq), 32'h0);
    wr(`WWT_OFS_CTRL, 32'h0);
    // counter clear bit
    ovf(1);
    rdchk(`WWT_OFS_CTRL, 32'h02);
    wr(`WWT_OFS_SHARED, 32'h83);
    repeat (3) @(posedge mclk);
    rdchk(`WWT_OFS_CTRL, 32'h00);
    rdchk(`WWT_OFS_SHARED, 32'h03);
    // shared offset goes to the load register when load target is set
    wr(`WWT_OFS_MODE, 32'h20);
    wr(`WWT_OFS_SHARED, 32'h55);
    rdchk(`WWT_OFS_COUNT, 32'h000aa000);
    rdchk(`WWT_OFS_SHARED, 32'h03);
    // interval taps and main-clock rates from a loaded start
    for (int i = 0; i < 5; i++) begin
      wr(`WWT_OFS_MODE, 32'h20);
      wr(`WWT_OFS_SHARED, tLoad[i]);
      wr(`WWT_OFS_STATUS, 32'h1);
      wr(`WWT_OFS_MODE, tMode[i]);
      wait_irq(n);
      chk(32'(n >= tTicks[i] - 4 && n <= tTicks[i] + 8), 32'h1);
    end
    // uncleared flag stays, cleared flag comes back one period later
    wr(`WWT_OFS_MODE, 32'h14);
    wr(`WWT_OFS_STATUS, 32'h1);
    wait_irq(n);
    chk(32'(n <= 2056), 32'h1);
    rdchk(`WWT_OFS_STATUS, 32'h1);
    // divided main-clock rates
    advance(32'h01, 2560, 0);
    chk(32'(dlt >= 9 && dlt <= 11), 32'h1);
    advance(32'h02, 2560, 0);
    chk(32'(dlt >= 19 && dlt <= 21), 32'h1);
    // stop mode halts main taps, sub-clock keeps counting
    stopMode <= 1'b1;
    advance(32'h02, 2560, 0);
    chk(dlt, 32'h0);
    l0 = lcdCount;
    advance(32'h00, 0, 5);
    chk(dlt, 32'h5);
    chk(32'(lcdCount - l0), 32'h5);
    // flag clear refused after stop release until a sub-clock edge
    stopMode <= 1'b0;
    @(posedge mclk);
    wr(`WWT_OFS_STATUS, 32'h1);
    rdchk(`WWT_OFS_STATUS, 32'h1);
    sub_rise(1);
    wr(`WWT_OFS_STATUS, 32'h1);
    rdchk(`WWT_OFS_STATUS, 32'h0);
    stop_test();
  end
endmodule
